// >>> verilog/flash_cmd_host.v
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"

module flash_cmd_host #(
  parameter [31:0] ERASE_LIMIT_CYC = `ERASE_LIMIT_DEF
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [4:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire        flash_ce_n,
  output wire        flash_we_n,
  output wire        flash_oe_n,
  output wire [20:0] flash_addr,
  output wire [7:0]  flash_dq_out,
  output wire        flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output wire        flash_wp_n
);
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_ISSUE = 3'd1;
  localparam [2:0] S_WAIT  = 3'd2;
  localparam [2:0] S_POLL  = 3'd3;
  localparam [2:0] S_PWAIT = 3'd4;
  localparam [2:0] S_SUSP  = 3'd5;
  localparam [31:0] PROG_LIMIT = `PROG_LIMIT_CYC;
  localparam [31:0] SUSP_WAIT  = `SUSP_CYC;

  reg [2:0]  state_r;
  reg [2:0]  op_r;
  reg [2:0]  step_r;
  reg [20:0] addr_r;
  reg [7:0]  wdata_r;
  reg [7:0]  rdata_r;
  reg        wp_r;
  reg        erasing_r;
  reg        erase_blk_r;
  reg [20:0] erase_addr_r;
  reg        suspended_r;
  reg        pend_susp_r;
  reg        timeout_r;
  reg        refused_r;
  reg        have_prev_r;
  reg        prev_bit_r;
  reg [31:0] timer_r;

  wire       cyc_done;
  wire [7:0] cyc_rdata;
  reg        cyc_start;
  reg [20:0] cyc_addr;
  reg [7:0]  cyc_data;

  // unlock pattern per step, last step carries the target
  function [20:0] seq_addr;
    input [2:0]  op;
    input [2:0]  step;
    input [20:0] a;
    begin
      seq_addr = a;
      if (op == `OP_PROG || op == `OP_SECT_ERASE || op == `OP_BLK_ERASE) begin
        case (step)
          3'd0: seq_addr = `UNLOCK_ADDR1;
          3'd1: seq_addr = `UNLOCK_ADDR2;
          3'd2: seq_addr = `UNLOCK_ADDR1;
          3'd3: seq_addr = (op == `OP_PROG) ? a : `UNLOCK_ADDR1;
          3'd4: seq_addr = `UNLOCK_ADDR2;
          default: seq_addr = a;
        endcase
      end
    end
  endfunction

  function [7:0] seq_data;
    input [2:0] op;
    input [2:0] step;
    input [7:0] d;
    begin
      case (step)
        3'd0: seq_data = `UNLOCK_DATA1;
        3'd1: seq_data = `UNLOCK_DATA2;
        3'd2: seq_data = (op == `OP_PROG) ? `CMD_PROG : `CMD_ERASE_SET;
        3'd3: seq_data = (op == `OP_PROG) ? d : `UNLOCK_DATA1;
        3'd4: seq_data = `UNLOCK_DATA2;
        default: seq_data = (op == `OP_SECT_ERASE) ? `CMD_SECT_ERASE : `CMD_BLK_ERASE;
      endcase
      if (op == `OP_SUSPEND)
        seq_data = `CMD_SUSPEND;
      if (op == `OP_RESUME)
        seq_data = `CMD_RESUME;
    end
  endfunction

  function [2:0] last_step;
    input [2:0] op;
    begin
      case (op)
        `OP_PROG:       last_step = 3'd3;
        `OP_SECT_ERASE: last_step = 3'd5;
        `OP_BLK_ERASE:  last_step = 3'd5;
        default:        last_step = 3'd0;
      endcase
    end
  endfunction

  // sector and block indices from the upper address bits
  function in_region;
    input [20:0] a;
    input        blk;
    input [20:0] e;
    begin
      if (blk)
        in_region = (a[20:`BLK_LSB] == e[20:`BLK_LSB]);
      else
        in_region = (a[20:`SECT_LSB] == e[20:`SECT_LSB]);
    end
  endfunction

  wire        ctrl_wr  = reg_wr && reg_addr == `REG_CTRL;
  wire [2:0]  new_op   = reg_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
  wire        idle     = state_r == S_IDLE;
  wire        is_erase = new_op == `OP_SECT_ERASE || new_op == `OP_BLK_ERASE;
  // judged with the protect level that this very write puts on the pin
  wire        boot_hit = addr_r[20:`BLK_LSB] == `BOOT_BLOCK && !reg_wdata[`CTRL_WP_BIT];
  wire        susp_hit = suspended_r && in_region(addr_r, erase_blk_r, erase_addr_r);
  wire        polling  = state_r == S_POLL || state_r == S_PWAIT;

  reg accept;
  reg take_susp;
  always @* begin
    accept    = 1'b0;
    take_susp = 1'b0;
    if (ctrl_wr && new_op != `OP_NONE) begin
      if (!idle)
        take_susp = new_op == `OP_SUSPEND && erasing_r && !suspended_r && polling && !pend_susp_r;
      else if (new_op == `OP_READ)
        accept = 1'b1;
      else if (new_op == `OP_PROG)
        accept = !susp_hit && !boot_hit;
      else if (is_erase)
        accept = !erasing_r && !boot_hit;
      else if (new_op == `OP_RESUME)
        accept = suspended_r;
    end
  end
  wire refuse_ev = ctrl_wr && new_op != `OP_NONE && !accept && !take_susp;

  wire cyc_wr = op_r != `OP_READ && state_r == S_ISSUE;
  always @* begin
    cyc_start = state_r == S_ISSUE || state_r == S_POLL;
    cyc_addr  = (state_r == S_ISSUE) ? seq_addr(op_r, step_r, addr_r) : addr_r;
    cyc_data  = seq_data(op_r, step_r, wdata_r);
  end

  wire [31:0] limit   = (op_r == `OP_PROG) ? PROG_LIMIT : ERASE_LIMIT_CYC;
  wire        new_bit = cyc_rdata[`POLL_BIT];
  reg         timeout_ev;

  always @(posedge core_clk) begin
    timeout_ev <= 1'b0;
    if (reset) begin
      state_r      <= S_IDLE;
      op_r         <= `OP_NONE;
      step_r       <= 3'd0;
      addr_r       <= 21'h000000;
      wdata_r      <= 8'h00;
      rdata_r      <= 8'h00;
      wp_r         <= `WP_RESET;
      erasing_r    <= 1'b0;
      erase_blk_r  <= 1'b0;
      erase_addr_r <= 21'h000000;
      suspended_r  <= 1'b0;
      pend_susp_r  <= 1'b0;
      have_prev_r  <= 1'b0;
      prev_bit_r   <= 1'b0;
      timer_r      <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `REG_ADDR && idle)
        addr_r <= reg_wdata[20:0];
      if (reg_wr && reg_addr == `REG_WDATA && idle)
        wdata_r <= reg_wdata[7:0];
      if (ctrl_wr && idle)
        wp_r <= reg_wdata[`CTRL_WP_BIT];        // steady while a sequence runs
      if (take_susp)
        pend_susp_r <= 1'b1;
      timer_r <= timer_r + 32'h00000001;
      case (state_r)
        S_IDLE: begin
          if (accept) begin
            op_r    <= new_op;
            step_r  <= 3'd0;
            state_r <= S_ISSUE;
          end
        end
        S_ISSUE: state_r <= S_WAIT;
        S_WAIT: begin
          if (cyc_done) begin
            if (op_r == `OP_READ) begin
              rdata_r <= cyc_rdata;             // array or toggle status
              state_r <= S_IDLE;
            end else if (step_r == last_step(op_r)) begin
              timer_r     <= 32'h00000000;
              have_prev_r <= 1'b0;
              state_r     <= S_POLL;
              if (op_r == `OP_SUSPEND) begin
                state_r <= S_SUSP;
              end else if (op_r == `OP_RESUME) begin
                suspended_r <= 1'b0;
                op_r        <= erase_blk_r ? `OP_BLK_ERASE : `OP_SECT_ERASE;
                addr_r      <= erase_addr_r;
              end else if (op_r != `OP_PROG) begin
                erasing_r    <= 1'b1;           // erase runs after the sixth pulse
                erase_blk_r  <= op_r == `OP_BLK_ERASE;
                erase_addr_r <= addr_r;
              end
            end else begin
              step_r  <= step_r + 3'd1;
              state_r <= S_ISSUE;
            end
          end
        end
        S_POLL: state_r <= S_PWAIT;
        S_PWAIT: begin
          if (cyc_done) begin
            prev_bit_r  <= new_bit;
            have_prev_r <= 1'b1;
            if (have_prev_r && prev_bit_r == new_bit) begin
              if (op_r != `OP_PROG || !suspended_r)
                erasing_r <= op_r == `OP_PROG && erasing_r;
              pend_susp_r <= 1'b0;
              state_r     <= S_IDLE;
            end else if (pend_susp_r) begin
              pend_susp_r <= 1'b0;
              op_r        <= `OP_SUSPEND;
              step_r      <= 3'd0;
              state_r     <= S_ISSUE;
            end else if (timer_r >= limit) begin
              timeout_ev  <= 1'b1;                    // program or erase bound
              pend_susp_r <= 1'b0;
              state_r     <= S_IDLE;
            end else begin
              state_r <= S_POLL;
            end
          end
        end
        S_SUSP: begin
          if (timer_r >= SUSP_WAIT) begin             // read mode after suspend
            suspended_r <= 1'b1;
            state_r     <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // sticky errors: set wins over a clear written to status
  wire st_clr = reg_wr && reg_addr == `REG_STATUS;
  always @(posedge core_clk) begin
    if (reset) begin
      timeout_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      timeout_r <= timeout_ev | (timeout_r & ~(st_clr & reg_wdata[`ST_TIMEOUT]));
      refused_r <= refuse_ev | (refused_r & ~(st_clr & reg_wdata[`ST_REFUSED]));
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL:   reg_rdata <= {28'h0000000, wp_r, op_r};
          `REG_ADDR:   reg_rdata <= {11'h000, addr_r};
          `REG_WDATA:  reg_rdata <= {24'h000000, wdata_r};
          `REG_STATUS: reg_rdata <= {26'h0000000, wp_r, refused_r, timeout_r,
                                     suspended_r, erasing_r, !idle};
          `REG_RDATA:  reg_rdata <= {24'h000000, rdata_r};
          default:     reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign flash_wp_n = wp_r;

  flash_bus_cycle u_cycle (
    .core_clk   (core_clk),
    .reset      (reset),
    .start      (cyc_start),
    .wr         (cyc_wr),
    .addr       (cyc_addr),
    .wdata      (cyc_data),
    .dq_in      (flash_dq_in),
    .ce_n       (flash_ce_n),
    .we_n       (flash_we_n),
    .oe_n       (flash_oe_n),
    .flash_addr (flash_addr),
    .dq_out     (flash_dq_out),
    .dq_oe      (flash_dq_oe),
    .rdata      (cyc_rdata),
    .done       (cyc_done)
  );
endmodule

// >>> pkg/flash_cmd_regs.vh
// Overview of operation
// - every command write: chip select and write strobe low
// - program: three unlock writes, then address/data
// - host erases target sector before programming (this host never issues an erase before a program)
// - host holds write protect steady per sequence
// - sector erase: six writes, last 50h, 4 KByte
// - block erase: six writes, last 30h, 64 KByte
// - 30h at any address resumes suspended erase
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// register port byte offsets
`define REG_CTRL       5'h00
`define REG_ADDR       5'h04
`define REG_WDATA      5'h08
`define REG_STATUS     5'h0c
`define REG_RDATA      5'h10

// control register fields
`define CTRL_OP_LSB    0
`define CTRL_OP_MSB    2
`define CTRL_WP_BIT    3
`define WP_RESET       1'b1

// status register fields
`define ST_BUSY        0
`define ST_ERASING     1
`define ST_SUSPENDED   2
`define ST_TIMEOUT     3
`define ST_REFUSED     4
`define ST_WP          5

// operation codes
`define OP_NONE        3'h0
`define OP_READ        3'h1
`define OP_PROG        3'h2
`define OP_SECT_ERASE  3'h3
`define OP_BLK_ERASE   3'h4
`define OP_SUSPEND     3'h5
`define OP_RESUME      3'h6

// unlock and command patterns
`define UNLOCK_ADDR1   21'h000aaa
`define UNLOCK_ADDR2   21'h000555
`define UNLOCK_DATA1   8'haa
`define UNLOCK_DATA2   8'h55
`define CMD_PROG       8'ha0
`define CMD_ERASE_SET  8'h80
`define CMD_SECT_ERASE 8'h50
`define CMD_BLK_ERASE  8'h30
`define CMD_SUSPEND    8'hb0
`define CMD_RESUME     8'h30

// address map
`define ADDR_W         21
`define SECT_LSB       12
`define BLK_LSB        16
`define BOOT_BLOCK     5'h00
`define POLL_BIT       6

// timing
`define CLK_NS         10
`define WE_LOW_NS      40
`define WE_LOW_CYC     ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define READ_ACC_NS    70
`define READ_ACC_CYC   ((`READ_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_LIMIT_NS  10000
`define PROG_LIMIT_CYC (`PROG_LIMIT_NS / `CLK_NS)
`define SUSP_NS        20000
`define SUSP_CYC       ((`SUSP_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_LIMIT_DEF 32'h004c4b40

`endif

// >>> verilog/flash_bus_cycle.v
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"

module flash_bus_cycle (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        start,
  input  wire        wr,
  input  wire [20:0] addr,
  input  wire [7:0]  wdata,
  input  wire [7:0]  dq_in,
  output reg         ce_n,
  output reg         we_n,
  output reg         oe_n,
  output reg  [20:0] flash_addr,
  output reg  [7:0]  dq_out,
  output reg         dq_oe,
  output reg  [7:0]  rdata,
  output reg         done
);
  localparam [1:0] C_IDLE = 2'd0;
  localparam [1:0] C_SET  = 2'd1;
  localparam [1:0] C_STRB = 2'd2;
  localparam [1:0] C_HOLD = 2'd3;
  localparam [31:0] WP_CYC32  = `WE_LOW_CYC - 1;
  localparam [31:0] ACC_CYC32 = `READ_ACC_CYC - 1;
  localparam [3:0]  WP_CNT    = WP_CYC32[3:0];
  localparam [3:0]  ACC_CNT   = ACC_CYC32[3:0];

  reg [1:0] state_r;
  reg [3:0] cnt_r;
  reg       wr_r;

  always @(posedge core_clk) begin
    done <= 1'b0;
    if (reset) begin
      state_r    <= C_IDLE;
      cnt_r      <= 4'h0;
      wr_r       <= 1'b0;
      ce_n       <= 1'b1;
      we_n       <= 1'b1;
      oe_n       <= 1'b1;
      flash_addr <= 21'h000000;
      dq_out     <= 8'h00;
      dq_oe      <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      case (state_r)
        C_IDLE: begin
          if (start) begin
            wr_r       <= wr;
            flash_addr <= addr;
            dq_out     <= wdata;
            dq_oe      <= wr;           // never drive while reading
            ce_n       <= 1'b0;
            state_r    <= C_SET;
          end
        end
        C_SET: begin
          if (wr_r) begin
            we_n  <= 1'b0;              // strobe under chip select
            cnt_r <= WP_CNT;
          end else begin
            oe_n  <= 1'b0;
            cnt_r <= ACC_CNT;
          end
          state_r <= C_STRB;
        end
        C_STRB: begin
          if (cnt_r == 4'h0) begin
            if (wr_r) begin
              we_n <= 1'b1;             // data still held past the rise
            end else begin
              rdata <= dq_in;
              oe_n  <= 1'b1;
            end
            state_r <= C_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        C_HOLD: begin
          ce_n    <= 1'b1;              // deselect between cycles
          dq_oe   <= 1'b0;
          done    <= 1'b1;
          state_r <= C_IDLE;
        end
        default: state_r <= C_IDLE;
      endcase
    end
  end
endmodule

// >>> test/flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
  parameter int PROG_NS  = 2000,
  parameter int ERASE_NS = 30000
) (
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        wp_n,
  input  wire [20:0] addr,
  input  wire [7:0]  din,
  output logic [7:0] dq
);
  logic [7:0]  mem [0:2097151];
  logic [20:0] la, ea, pa, base;
  logic [7:0]  pd, last;
  int          step, left;
  bit          prog, ers, susp, hold, blk, tg;
  function automatic bit in_reg(input logic [20:0] a);
    return blk ? a[20:16] == ea[20:16] : a[20:12] == ea[20:12];
  endfunction
  initial begin
    for (int i = 0; i < 2097152; i++) mem[i] = 8'hff;
    step = 0;
    last = 8'h00;
  end
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) begin
    if (prog) begin
    end else if (ers && !susp) begin
      if (din == 8'hb0) hold = 1'b1;
    end else if (susp && step == 0 && din == 8'h30) begin
      susp = 1'b0;
    end else begin
      case (step)
        0: step = (la == 21'haaa && din == 8'haa) ? 1 : 0;
        1: step = (la == 21'h555 && din == 8'h55) ? 2 : 0;
        2: step = (la != 21'haaa) ? 0 : (din == 8'ha0) ? 6 : (din == 8'h80 && !ers) ? 3 : 0;
        3: step = (la == 21'haaa && din == 8'haa) ? 4 : 0;
        4: step = (la == 21'h555 && din == 8'h55) ? 5 : 0;
        5: begin
          step = 0;
          if ((din == 8'h50 || din == 8'h30) && (wp_n || la[20:16] != 5'h00)) begin
            ers = 1'b1;
            blk = din == 8'h30;
            ea = la;
            base = blk ? {la[20:16], 16'h0} : {la[20:12], 12'h0};
            left = ERASE_NS;
          end
        end
        default: begin
          step = 0;
          if (!(susp && in_reg(la))) begin
            pa = la;
            pd = din;
            prog = 1'b1;
          end
        end
      endcase
    end
  end
  always @(posedge prog) begin
    #(PROG_NS);
    mem[pa] = mem[pa] & pd;
    prog = 1'b0;
  end
  always #100 begin
    if (hold) begin
      susp = 1'b1;
      hold = 1'b0;
    end
    if (ers && !susp && !prog) left -= 100;
    if (ers && left <= 0) begin
      for (int i = 0; i < (blk ? 65536 : 4096); i++) mem[base + i] = 8'hff;
      ers = 1'b0;
    end
  end
  always @(posedge oe_n) if (!ce_n) tg = ~tg;
  // while deselected, dq shows the inverse of the last value read
  always @(dq) if (!ce_n && !oe_n) last = dq;
  always_comb begin
    if (ce_n || oe_n) dq = ~last;
    else if (prog) dq = {~pd[7], tg, mem[addr][5:0]};
    else if (ers && !susp) dq = {1'b0, tg, 3'b000, tg, 2'b00};
    else if (ers && in_reg(addr)) dq = {2'b11, 3'b000, tg, 2'b00};
    else dq = mem[addr];
  end
endmodule

// >>> test/flash_cmd_host_asserts.sv
`timescale 1ns/100ps
module flash_cmd_host_asserts #(
  parameter [31:0] ERASE_LIMIT_CYC = 32'h004c4b40
) (
  input wire        core_clk,
  input wire        reset,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_oe_n,
  input wire [20:0] flash_addr,
  input wire [7:0]  flash_dq_out,
  input wire        flash_dq_oe,
  input wire        flash_wp_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  we_with_ce_a: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without select");
  rw_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes together");
  dq_drive_a: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven during read");
  we_pulse_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe length");
  wr_hold_a: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe)
    else $error("write cycle not held");
  ce_after_we_a: assert property ($rose(flash_we_n) |=> flash_ce_n && !flash_dq_oe)
    else $error("select not released");
  oe_pulse_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*7] ##1 flash_oe_n)
    else $error("read strobe length");
  wp_steady_a: assert property (!flash_ce_n |-> $stable(flash_wp_n))
    else $error("write protect moved in cycle");
endmodule
bind flash_cmd_host flash_cmd_host_asserts #(.ERASE_LIMIT_CYC(ERASE_LIMIT_CYC)) i_flash_cmd_host_asserts (
  .core_clk(core_clk), .reset(reset), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_wp_n(flash_wp_n));

// >>> test/parallel_nor_flash_command_unit_tb_top.sv
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module parallel_nor_flash_command_unit_tb_top;
  logic        core_clk, reset, reg_wr, reg_rd;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, st;
  logic [7:0]  v;
  wire  [31:0] reg_rdata;
  wire         ce_n, we_n, oe_n, dq_oe, wp_n;
  wire  [20:0] faddr;
  wire  [7:0]  dout, din;
  int          fails, num_checks;
  flash_cmd_host #(.ERASE_LIMIT_CYC(32'd20000)) i_flash_cmd_host (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_addr(faddr), .flash_dq_out(dout), .flash_dq_oe(dq_oe), .flash_dq_in(din), .flash_wp_n(wp_n));
  flash_dev_model i_flash_dev_model (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .wp_n(wp_n), .addr(faddr), .din(dout), .dq(din));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(`REG_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20000);
    chk(st[0], 1'b0);
  endtask
  task automatic op(input logic [2:0] code, input logic [20:0] a, input logic [7:0] d, input logic wp);
    wr(`REG_ADDR, {11'h0, a});
    wr(`REG_WDATA, {24'h0, d});
    wr(`REG_CTRL, {28'h0, wp, code});
    idle();
  endtask
  task automatic rd_flash(input logic [20:0] a);
    op(`OP_READ, a, 8'h00, 1'b1);
    rd(`REG_RDATA, st);
    v = st[7:0];
  endtask
  task automatic s_reset;
    chk({ce_n, we_n, oe_n, dq_oe, wp_n}, 5'b11101);
    rd(5'h1c, st);
    chk(st, 32'h0);
    rd(`REG_STATUS, st);
    chk(st[4:0], 5'h00);
  endtask
  task automatic s_prog;
    rd_flash(21'h012345);
    chk(v, 8'hff);
    op(`OP_PROG, 21'h012345, 8'h3c, 1'b1);
    chk(st[4:3], 2'b00);
    chk(i_flash_dev_model.mem[21'h012345], 8'h3c);
    rd_flash(21'h012345);
    chk(v, 8'h3c);
  endtask
  task automatic s_suspend;
    op(`OP_PROG, 21'h023010, 8'h00, 1'b1);
    wr(`REG_ADDR, {11'h0, 21'h023000});
    wr(`REG_CTRL, {28'h0, 1'b1, `OP_SECT_ERASE});
    repeat (100) @(posedge core_clk);
    wr(`REG_CTRL, {28'h0, 1'b1, `OP_SUSPEND});
    idle();
    chk(st[2:1], 2'b11);
    rd_flash(21'h023010);
    chk(v[7:6], 2'b11);
    rd_flash(21'h012345);
    chk(v, 8'h3c);
    op(`OP_PROG, 21'h024000, 8'ha5, 1'b1);
    chk(i_flash_dev_model.mem[21'h024000], 8'ha5);
    op(`OP_PROG, 21'h023020, 8'h11, 1'b1);
    chk(st[4], 1'b1);
    wr(`REG_STATUS, 32'h18);
    op(`OP_RESUME, 21'h000000, 8'h00, 1'b1);
    chk(st[4:1], 4'h0);
    rd_flash(21'h023010);
    chk(v, 8'hff);
    chk(i_flash_dev_model.mem[21'h024000], 8'ha5);
  endtask
  task automatic s_block;
    wr(`REG_ADDR, {11'h0, 21'h00abcd});
    wr(`REG_CTRL, {28'h0, 1'b0, `OP_BLK_ERASE});
    rd(`REG_STATUS, st);
    chk(st[4], 1'b1);
    chk(wp_n, 1'b0);
    chk(st[0], 1'b0);
    wr(`REG_STATUS, 32'h10);
    op(`OP_BLK_ERASE, 21'h02abcd, 8'h00, 1'b1);
    chk(i_flash_dev_model.mem[21'h024000], 8'hff);
    chk(i_flash_dev_model.mem[21'h012345], 8'h3c);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #900000;
    fails++;
    tally_and_finish();
  end
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    s_reset();
    s_prog();
    s_suspend();
    s_block();
    tally_and_finish();
  end
endmodule
